// [rtl/rt_mode_pkg.sv]
// Overview of operation
// - mode 10000 with transmit bit means vector
// - good vector: clear ME, BCR; status plus vector
// - vector from buffer, or descriptor word 4
// - vector done: clear flags, toggle buffer, interrupt
// - broadcast vector: no status, error flags, interrupts
// - invalid or undefined-invalid command: ignore entirely
// - receive-bit form, not illegal: answer in form
// - receive-bit form, illegal: message error, illegal flag
// - data after vector: no status, count error
// - mode 10001 with transmit bit means synchronize
// - sync data stored in buffer or word 4
// - even load option loads word when bit0 zero
// - odd load option loads word when bit0 one
// - both options set: load every sync word
// - time-tag load completes before status goes out
package rt_mode_pkg;

  // register offsets on the host port
  localparam logic [15:0] CFG_OFS      = 16'h0017;
  localparam logic [15:0] IRQ_STAT_OFS = 16'h0018;
  localparam logic [15:0] IRQ_MASK_OFS = 16'h0019;
  localparam logic [15:0] ILL_TAB_OFS  = 16'h001A;
  localparam logic [15:0] DCW_OFS      = 16'h001B;
  localparam logic [15:0] MIW_OFS      = 16'h001C;
  localparam logic [15:0] TTAG_OFS     = 16'h001D;
  localparam logic [15:0] MEM_BASE_OFS = 16'h0020;
  localparam logic [15:0] MEM_LAST_OFS = 16'h0023;

  // configuration fields
  localparam int CFG_LOAD_EVEN = 0;
  localparam int CFG_LOAD_ODD  = 1;
  localparam int CFG_UMC_INV   = 2;
  localparam int CFG_SIMPLIFIED_MODE_COMMAND_PROCESSING      = 3;
  localparam int CFG_ADDR_LO   = 4;
  localparam int CFG_ADDR_HI   = 8;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // interrupt bits
  localparam int IRQ_WORD_ACC = 0;
  localparam int IRQ_BROADCAST_FLAG    = 1;
  localparam int IRQ_MSG_ERR  = 2;
  localparam int IRQ_ILL_CMD  = 3;
  localparam int IRQ_W        = 4;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  // illegalization table bits, receive-bit forms
  localparam int ILL_VECTOR = 0;
  localparam int ILL_SYNC   = 1;
  localparam logic [1:0] ILL_RESET = 2'h0;

  // descriptor control word fields
  localparam int DCW_ACCESSED = 0;
  localparam int DCW_BROADCAST_FLAG    = 1;
  localparam int DCW_PINGPONG = 2;

  // message info word layout: iwderr,word_count_error,terminal_to_terminal_flag,illegal_command_flag,message_error_flag,receiving_bus_id
  localparam int MIW_W = 6;

  // command word layout and codes
  localparam int CW_TR = 10;
  localparam logic [4:0] MC_VECTOR  = 5'h10;
  localparam logic [4:0] MC_SYNC    = 5'h11;
  localparam logic [4:0] BROADCAST_FLAG_ADDR = 5'h1F;
  localparam logic [4:0] SA_MODE_LO = 5'h00;
  localparam logic [4:0] SA_MODE_HI = 5'h1F;

  // status word bits
  localparam int SW_ME  = 10;
  localparam int SW_BCR = 4;

  // buffer memory: two ping-pong words, then descriptor word 4
  localparam int MEM_AW = 2;
  localparam logic [1:0] MEM_DESC4 = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_WAIT   = 2'b01,
    ST_FETCH  = 2'b11,
    ST_FINISH = 2'b10
  } fsm_t;

endpackage : rt_mode_pkg

// [rtl/rt_buf_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface rt_buf_if #(
  parameter int AW = 2,
  parameter int DW = 16
);
  logic          a_we;
  logic [AW-1:0] a_addr;
  logic [DW-1:0] a_wdata;
  logic [DW-1:0] a_rdata;
  logic          b_we;
  logic [AW-1:0] b_addr;
  logic [DW-1:0] b_wdata;
  logic [DW-1:0] b_rdata;

  modport ctrl (
    output a_we, a_addr, a_wdata, b_we, b_addr, b_wdata,
    input  a_rdata, b_rdata
  );
  modport store (
    input  a_we, a_addr, a_wdata, b_we, b_addr, b_wdata,
    output a_rdata, b_rdata
  );
endinterface : rt_buf_if
`default_nettype wire

// [rtl/rt_buf_mem.sv]
`timescale 1ns/1ns
`default_nettype none
module rt_buf_mem #(
  parameter int AW = 2,
  parameter int DW = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  rt_buf_if.store  bus
);
  logic [DW-1:0] mem [2**AW];

  // port b is the terminal's side and wins a write clash
  always_ff @(posedge ref_clk) begin
    if (bus.a_we && !(bus.b_we && bus.b_addr == bus.a_addr)) begin
      mem[bus.a_addr] <= bus.a_wdata;
    end
    if (bus.b_we) begin
      mem[bus.b_addr] <= bus.b_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bus.a_rdata <= '0;
      bus.b_rdata <= '0;
    end else begin
      bus.a_rdata <= mem[bus.a_addr];
      bus.b_rdata <= mem[bus.b_addr];
    end
  end
endmodule : rt_buf_mem
`default_nettype wire

// [rtl/rt_vector_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module rt_vector_sync #(
  parameter int DW = 16
) (
  input  wire logic          ref_clk,
  input  wire logic          srst,
  input  wire logic [15:0]   reg_addr,
  input  wire logic [15:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [15:0]        reg_rdata,
  input  wire logic          cmd_strobe,
  input  wire logic [15:0]   cmd_word,
  input  wire logic          cmd_ok,
  input  wire logic          cmd_bus,
  input  wire logic          data_strobe,
  input  wire logic [DW-1:0] data_word,
  input  wire logic          data_ok,
  input  wire logic          msg_end,
  output logic               status_tx,
  output logic [15:0]        status_word,
  output logic               vector_tx,
  output logic [DW-1:0]      vector_word,
  output logic [15:0]        time_tag,
  output logic               irq
);

  typedef struct packed {
    rt_mode_pkg::fsm_t st;
    logic              is_vec;
    logic              tr;
    logic              bc;
    logic              bus;
    logic              resp;
    logic              fetch;
    logic              me;
    logic              descriptor_accessed_flag_v;
    logic              broadcast_flag_v;
    logic              message_error_flag;
    logic              illegal_command_flag;
    logic              wct;
    logic              iwd;
    logic [3:0]        ev;
    logic [15:0]       cfg;
    logic [3:0]        mask;
    logic [3:0]        istat;
    logic [1:0]        illtab;
    logic              descriptor_accessed_flag;
    logic              broadcast_flag;
    logic              pingpong_buffer_select;
    logic [5:0]        miw;
    logic [15:0]       ttag;
    logic              sme;
    logic              sbcr;
    logic              stx;
    logic              vtx;
    logic [DW-1:0]     vword;
    logic [15:0]       rdata;
    logic              rd_mem;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  rt_buf_if #(.AW(rt_mode_pkg::MEM_AW), .DW(DW)) buf_port ();

  rt_buf_mem #(.AW(rt_mode_pkg::MEM_AW), .DW(DW)) u_mem (
    .ref_clk (ref_clk),
    .srst    (srst),
    .bus     (buf_port.store)
  );

  logic [4:0]                     own_addr;
  logic [4:0]                     cmd_rt;
  logic [4:0]                     cmd_sa;
  logic [4:0]                     cmd_code;
  logic                           addressed;
  logic                           mode_cmd;
  logic                           known;
  logic                           host_mem;
  logic [rt_mode_pkg::MEM_AW-1:0] buf_sel;
  logic [3:0]                     clr;
  logic [3:0]                     ev_now;
  logic                           ttag_hit;

  assign own_addr  = s_r.cfg[rt_mode_pkg::CFG_ADDR_HI:
                             rt_mode_pkg::CFG_ADDR_LO];
  assign cmd_rt    = cmd_word[15:11];
  assign cmd_sa    = cmd_word[9:5];
  assign cmd_code  = cmd_word[4:0];
  assign addressed = (cmd_rt == own_addr) ||
                     (cmd_rt == rt_mode_pkg::BROADCAST_FLAG_ADDR);
  assign mode_cmd  = (cmd_sa == rt_mode_pkg::SA_MODE_LO) ||
                     (cmd_sa == rt_mode_pkg::SA_MODE_HI);
  assign known     = (cmd_code == rt_mode_pkg::MC_VECTOR) ||
                     (cmd_code == rt_mode_pkg::MC_SYNC);
  assign host_mem  = (reg_addr >= rt_mode_pkg::MEM_BASE_OFS) &&
                     (reg_addr <= rt_mode_pkg::MEM_LAST_OFS);

  // simplified processing keeps the word in descriptor word 4
  assign buf_sel = s_r.cfg[rt_mode_pkg::CFG_SIMPLIFIED_MODE_COMMAND_PROCESSING] ?
                   rt_mode_pkg::MEM_DESC4 : {1'b0, s_r.pingpong_buffer_select};

  // either option bit matching bit 0 loads; both set loads all
  assign ttag_hit =
    (s_r.cfg[rt_mode_pkg::CFG_LOAD_EVEN] && !data_word[0]) ||
    (s_r.cfg[rt_mode_pkg::CFG_LOAD_ODD]  &&  data_word[0]);

  assign clr = (reg_wr && reg_addr == rt_mode_pkg::IRQ_STAT_OFS) ?
               reg_wdata[3:0] : 4'h0;

  always_comb begin
    s_nxt     = s_r;
    s_nxt.stx = 1'b0;
    s_nxt.vtx = 1'b0;
    s_nxt.ttag = s_r.ttag + 16'h0001;
    ev_now    = 4'h0;

    buf_port.a_we    = 1'b0;
    buf_port.a_addr  = reg_addr[rt_mode_pkg::MEM_AW-1:0];
    buf_port.a_wdata = reg_wdata[DW-1:0];
    buf_port.b_we    = 1'b0;
    buf_port.b_addr  = buf_sel;
    buf_port.b_wdata = data_word;

    // host writes
    if (reg_wr) begin
      if (reg_addr == rt_mode_pkg::CFG_OFS) begin
        s_nxt.cfg = reg_wdata;
      end else if (reg_addr == rt_mode_pkg::IRQ_MASK_OFS) begin
        s_nxt.mask = reg_wdata[3:0];
      end else if (reg_addr == rt_mode_pkg::ILL_TAB_OFS) begin
        s_nxt.illtab = reg_wdata[1:0];
      end else if (reg_addr == rt_mode_pkg::DCW_OFS) begin
        s_nxt.pingpong_buffer_select = reg_wdata[rt_mode_pkg::DCW_PINGPONG];
      end else if (host_mem) begin
        buf_port.a_we = 1'b1;
      end
    end

    // host reads, answered in the next cycle
    s_nxt.rdata  = 16'h0000;
    s_nxt.rd_mem = 1'b0;
    if (reg_rd) begin
      if (reg_addr == rt_mode_pkg::CFG_OFS) begin
        s_nxt.rdata = s_r.cfg;
      end else if (reg_addr == rt_mode_pkg::IRQ_STAT_OFS) begin
        s_nxt.rdata = {12'h000, s_r.istat};
      end else if (reg_addr == rt_mode_pkg::IRQ_MASK_OFS) begin
        s_nxt.rdata = {12'h000, s_r.mask};
      end else if (reg_addr == rt_mode_pkg::ILL_TAB_OFS) begin
        s_nxt.rdata = {14'h0000, s_r.illtab};
      end else if (reg_addr == rt_mode_pkg::DCW_OFS) begin
        s_nxt.rdata = {13'h0000, s_r.pingpong_buffer_select, s_r.broadcast_flag, s_r.descriptor_accessed_flag};
      end else if (reg_addr == rt_mode_pkg::MIW_OFS) begin
        s_nxt.rdata = {10'h000, s_r.miw};
      end else if (reg_addr == rt_mode_pkg::TTAG_OFS) begin
        s_nxt.rdata = s_r.ttag;
      end else if (host_mem) begin
        s_nxt.rd_mem = 1'b1;
      end
    end

    case (s_r.st)
      rt_mode_pkg::ST_IDLE: begin
        // invalid words and undefined-invalid receive forms leave no trace
        if (cmd_strobe && cmd_ok && addressed && mode_cmd && known &&
            !(!cmd_word[rt_mode_pkg::CW_TR] &&
              s_r.cfg[rt_mode_pkg::CFG_UMC_INV])) begin
          s_nxt.st     = rt_mode_pkg::ST_WAIT;
          s_nxt.is_vec = (cmd_code == rt_mode_pkg::MC_VECTOR);
          s_nxt.tr     = cmd_word[rt_mode_pkg::CW_TR];
          s_nxt.bc     = (cmd_rt == rt_mode_pkg::BROADCAST_FLAG_ADDR);
          s_nxt.bus    = cmd_bus;
        end
      end

      rt_mode_pkg::ST_WAIT: begin
        // error defaults, cleared by the good outcomes below
        s_nxt.resp    = 1'b0;
        s_nxt.fetch   = 1'b0;
        s_nxt.me      = 1'b1;
        s_nxt.descriptor_accessed_flag_v  = 1'b1;
        s_nxt.broadcast_flag_v = s_r.bc;
        s_nxt.message_error_flag    = 1'b1;
        s_nxt.illegal_command_flag   = 1'b0;
        s_nxt.wct     = 1'b0;
        s_nxt.iwd     = 1'b0;
        s_nxt.ev      = 4'h0;
        s_nxt.ev[rt_mode_pkg::IRQ_WORD_ACC] = 1'b1;
        s_nxt.ev[rt_mode_pkg::IRQ_BROADCAST_FLAG]    = s_r.bc;
        s_nxt.ev[rt_mode_pkg::IRQ_MSG_ERR]  = 1'b1;
        if (data_strobe) begin
          s_nxt.st = rt_mode_pkg::ST_FINISH;
          if (!s_r.is_vec && s_r.tr) begin
            if (data_ok) begin
              buf_port.b_we = 1'b1;
              if (ttag_hit) begin
                // loaded here, status leaves a cycle later
                s_nxt.ttag = data_word[15:0];
              end
              s_nxt.resp    = !s_r.bc;
              s_nxt.me      = 1'b0;
              s_nxt.descriptor_accessed_flag_v  = 1'b0;
              s_nxt.broadcast_flag_v = 1'b0;
              s_nxt.message_error_flag    = 1'b0;
              s_nxt.ev      = 4'h0;
              s_nxt.ev[rt_mode_pkg::IRQ_WORD_ACC] = 1'b1;
            end else begin
              s_nxt.iwd = 1'b1;
            end
          end else begin
            // word after a command that takes none
            s_nxt.broadcast_flag_v = 1'b0;
            s_nxt.wct     = 1'b1;
          end
        end else if (msg_end) begin
          s_nxt.st = rt_mode_pkg::ST_FINISH;
          if (!s_r.is_vec && s_r.tr) begin
            // sync command that never got its data word
            s_nxt.broadcast_flag_v = 1'b0;
            s_nxt.wct     = 1'b1;
          end else if (s_r.tr) begin
            if (!s_r.bc) begin
              s_nxt.st      = rt_mode_pkg::ST_FETCH;
              s_nxt.resp    = 1'b1;
              s_nxt.fetch   = 1'b1;
              s_nxt.me      = 1'b0;
              s_nxt.descriptor_accessed_flag_v  = 1'b0;
              s_nxt.broadcast_flag_v = 1'b0;
              s_nxt.message_error_flag    = 1'b0;
              s_nxt.ev      = 4'h0;
              s_nxt.ev[rt_mode_pkg::IRQ_WORD_ACC] = 1'b1;
            end
            // broadcast vector keeps the error defaults
          end else begin
            s_nxt.resp = !s_r.bc;
            if (s_r.illtab[s_r.is_vec ? rt_mode_pkg::ILL_VECTOR :
                                        rt_mode_pkg::ILL_SYNC]) begin
              s_nxt.illegal_command_flag = 1'b1;
              s_nxt.ev[rt_mode_pkg::IRQ_MSG_ERR] = 1'b0;
              s_nxt.ev[rt_mode_pkg::IRQ_ILL_CMD] = 1'b1;
            end else begin
              s_nxt.me   = 1'b0;
              s_nxt.message_error_flag = 1'b0;
              s_nxt.ev[rt_mode_pkg::IRQ_MSG_ERR] = 1'b0;
            end
          end
        end else if (cmd_strobe) begin
          // a fresh command ends the one pending, which is dropped
          s_nxt.st = rt_mode_pkg::ST_IDLE;
        end
      end

      rt_mode_pkg::ST_FETCH: begin
        // buffer word read at the msg_end edge is ready now
        s_nxt.vword = buf_port.b_rdata;
        s_nxt.st    = rt_mode_pkg::ST_FINISH;
      end

      rt_mode_pkg::ST_FINISH: begin
        s_nxt.stx   = s_r.resp;
        s_nxt.vtx   = s_r.resp && s_r.fetch;
        s_nxt.sme   = s_r.me;
        s_nxt.sbcr  = s_r.bc;
        s_nxt.descriptor_accessed_flag  = s_r.descriptor_accessed_flag_v;
        s_nxt.broadcast_flag = s_r.broadcast_flag_v;
        s_nxt.pingpong_buffer_select   = ~s_r.pingpong_buffer_select;
        s_nxt.miw   = {s_r.iwd, s_r.wct, 1'b0,
                       s_r.illegal_command_flag, s_r.message_error_flag, s_r.bus};
        ev_now      = s_r.ev;
        s_nxt.st    = rt_mode_pkg::ST_IDLE;
      end

      default: begin
        s_nxt.st = rt_mode_pkg::ST_IDLE;
      end
    endcase

    // a new event outweighs a clear in the same cycle
    s_nxt.istat = (s_r.istat & ~clr) | ev_now;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_r        <= '0;
      s_r.st     <= rt_mode_pkg::ST_IDLE;
      s_r.cfg    <= rt_mode_pkg::CFG_RESET;
      s_r.mask   <= rt_mode_pkg::IRQ_RESET;
      s_r.istat  <= rt_mode_pkg::IRQ_RESET;
      s_r.illtab <= rt_mode_pkg::ILL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata   = s_r.rd_mem ? buf_port.a_rdata : s_r.rdata;
  assign status_tx   = s_r.stx;
  assign status_word = {own_addr, s_r.sme, 5'h00, s_r.sbcr, 4'h0};
  assign vector_tx   = s_r.vtx;
  assign vector_word = s_r.vword;
  assign time_tag    = s_r.ttag;
  assign irq         = |(s_r.istat & s_r.mask);

endmodule : rt_vector_sync
`default_nettype wire

// [tb/rt_vector_sync_properties.sv]
`timescale 1ns/1ns
`default_nettype none
module rt_vector_sync_properties #(
  parameter int DW = 16
) (
  input wire logic          ref_clk,
  input wire logic          srst,
  input wire logic [15:0]   reg_addr,
  input wire logic [15:0]   reg_wdata,
  input wire logic          reg_wr,
  input wire logic          cmd_strobe,
  input wire logic [15:0]   cmd_word,
  input wire logic          cmd_ok,
  input wire logic          data_strobe,
  input wire logic [DW-1:0] data_word,
  input wire logic          data_ok,
  input wire logic          msg_end,
  input wire logic          status_tx,
  input wire logic [15:0]   status_word,
  input wire logic          vector_tx,
  input wire logic [15:0]   time_tag
);
  logic [15:0] cfg_r;
  logic        hit;
  logic        ld;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // shadow of the configuration word, seen only through host writes
  always_ff @(posedge ref_clk) begin
    if (srst)
      cfg_r <= 16'h0000;
    else if (reg_wr && reg_addr == 16'h0017)
      cfg_r <= reg_wdata;
  end
  assign hit = cmd_strobe && cmd_ok && cmd_word[15:11] == cfg_r[8:4]
    && (cmd_word[9:5] == 5'h00 || cmd_word[9:5] == 5'h1F);
  assign ld = data_word[0] ? cfg_r[1] : cfg_r[0];
  sequence s_vec;
    hit && cmd_word[10] && cmd_word[4:0] == 5'h10;
  endsequence
  sequence s_sync;
    hit && cmd_word[10] && cmd_word[4:0] == 5'h11 ##1 data_strobe && data_ok;
  endsequence
  property p_vec_time;
    s_vec ##1 msg_end |-> ##3 status_tx && vector_tx;
  endproperty
  property p_vec_ok;
    vector_tx |-> status_tx && !status_word[10] && !status_word[4];
  endproperty
  property p_vec_data;
    s_vec ##1 data_strobe |=> !status_tx [*6];
  endproperty
  property p_bc;
    cmd_strobe && cmd_ok && cmd_word[15:11] == 5'h1F |=> !status_tx [*6];
  endproperty
  property p_ign;
    cmd_strobe && (!cmd_ok || !cmd_word[10] && cfg_r[2]) |=> !status_tx [*6];
  endproperty
  property p_form;
    hit && !cmd_word[10] && !cfg_r[2] && cmd_word[4:0] == 5'h10 ##1 msg_end
      |-> ##2 status_tx && !vector_tx;
  endproperty
  property p_sync;
    s_sync |-> ##2 status_tx && !status_word[10];
  endproperty
  property p_load;
    s_sync ##0 ld |-> ##2 time_tag == $past(data_word, 2) + 16'h0001;
  endproperty
  property p_hold;
    s_sync ##0 !ld |=> time_tag == $past(time_tag) + 16'h0001;
  endproperty
  a_vec_time: assert property (p_vec_time) else $error("vector late");
  a_vec_ok: assert property (p_vec_ok) else $error("vector status");
  a_vec_data: assert property (p_vec_data) else $error("status sent");
  a_bc: assert property (p_bc) else $error("broadcast answered");
  a_ign: assert property (p_ign) else $error("invalid answered");
  a_form: assert property (p_form) else $error("no form reply");
  a_sync: assert property (p_sync) else $error("sync reply");
  a_load: assert property (p_load) else $error("no load");
  a_hold: assert property (p_hold) else $error("stray load");
endmodule : rt_vector_sync_properties
`default_nettype wire

// [tb/rt_bus_ctrl_model.sv]
`timescale 1ns/1ns
`default_nettype none
module rt_bus_ctrl_model (
  input  wire logic        ref_clk,
  output logic             cmd_strobe,
  output logic [15:0]      cmd_word,
  output logic             cmd_ok,
  output logic             cmd_bus,
  output logic             data_strobe,
  output logic [15:0]      data_word,
  output logic             data_ok,
  output logic             msg_end
);
  initial begin
    {cmd_strobe, cmd_ok, cmd_bus, data_strobe, data_ok, msg_end} = 6'h00;
    cmd_word = 16'h0000;
    data_word = 16'h0000;
  end
  // kind: 0 idle, 1 command, 2 data word, 3 end of message
  task automatic xfer(input logic [1:0] kind, input logic [15:0] w,
                      input logic ok, input logic bus);
    @(posedge ref_clk);
    cmd_strobe <= kind == 2'h1;
    data_strobe <= kind == 2'h2;
    msg_end <= kind == 2'h3;
    cmd_ok <= ok;
    data_ok <= ok;
    cmd_bus <= bus;
    // lines not carrying this call's word invert the previous word on each call, so the last word comes back every second call
    cmd_word <= kind == 2'h1 ? w : ~cmd_word;
    data_word <= kind == 2'h2 ? w : ~data_word;
  endtask : xfer
endmodule : rt_bus_ctrl_model
`default_nettype wire

// [tb/tb_rt_vector_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_rt_vector_sync;
  logic        ref_clk, srst, reg_wr, reg_rd, status_tx, vector_tx, irq;
  logic        cmd_strobe, cmd_ok, cmd_bus, data_strobe, data_ok, msg_end;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, cmd_word, data_word;
  logic [15:0] status_word, vector_word, time_tag, st_vw, st_tt, v, dw;
  logic [15:0] vbuf [2];
  logic        st_vec, pp, pp_b, bus_r;
  logic [4:0]  rt;
  logic [3:0]  mask_m;
  logic [2:0]  l_dcw;
  logic [5:0]  l_miw;
  int          n_errors, num_checks, cyc, n_st, st_cyc;
  rt_vector_sync #(.DW(16)) uut (.ref_clk(ref_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_strobe(cmd_strobe),
    .cmd_word(cmd_word), .cmd_ok(cmd_ok), .cmd_bus(cmd_bus),
    .data_strobe(data_strobe), .data_word(data_word), .data_ok(data_ok),
    .msg_end(msg_end), .status_tx(status_tx), .status_word(status_word),
    .vector_tx(vector_tx), .vector_word(vector_word),
    .time_tag(time_tag), .irq(irq));
  rt_bus_ctrl_model bc (.ref_clk(ref_clk), .cmd_strobe(cmd_strobe),
    .cmd_word(cmd_word), .cmd_ok(cmd_ok), .cmd_bus(cmd_bus),
    .data_strobe(data_strobe), .data_word(data_word), .data_ok(data_ok),
    .msg_end(msg_end));
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (status_tx === 1'b1) begin
      n_st <= n_st + 1;
      st_cyc <= cyc;
      st_vec <= vector_tx;
      st_vw <= vector_word;
      st_tt <= time_tag;
    end
  end
  function automatic logic [15:0] cw(logic [4:0] a, logic t, logic [4:0] c);
    return {a, t, 5'h00, c};
  endfunction : cw
  function automatic logic loads(logic [1:0] e, logic b);
    return b ? e[1] : e[0];
  endfunction : loads
  task automatic summarize();
    if (n_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic check(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // one message on the bus, then status, descriptor, info word and irq
  task automatic run(input logic [15:0] c, input logic ok, input logic ok_c,
    input logic dat, input logic [15:0] d, input logic fin, input int dly,
    input logic [1:0] sw, input logic [1:0] dcw, input logic [5:0] miw,
    input logic [3:0] ist);
    int n0;
    int mark;
    n0 = n_st;
    mark = 0;
    bus_r = 1'($urandom);
    pp_b = pp;
    bc.xfer(2'h1, c, ok, bus_r);
    if (dat) begin
      bc.xfer(2'h2, d, 1'b1, bus_r);
      mark = cyc + 1;
    end
    if (fin) begin
      bc.xfer(2'h3, 16'h0000, 1'b1, bus_r);
      mark = cyc + 1;
    end
    bc.xfer(2'h0, 16'h0000, 1'b0, bus_r);
    repeat (8) @(posedge ref_clk);
    if (ok_c) begin
      pp = ~pp;
      l_dcw = {pp, dcw};
      l_miw = {miw[5:1], bus_r};
    end
    check(n_st - n0 == (dly > 0), "status count");
    check(dly == 0 || st_cyc - mark == dly && st_vec === (dly == 3), "time");
    check(dly != 3 || st_vw === d, "vector word");
    check(status_word === {rt, sw[1], 5'h00, sw[0], 4'h0}, "status word");
    rd(16'h001B, v);
    check(v[2:0] === l_dcw, "descriptor");
    rd(16'h001C, v);
    check(v[5:0] === l_miw, "info word");
    rd(16'h0018, v);
    check(v[3:0] === ist && irq === |(ist & mask_m), "irq");
    wr(16'h0018, 16'h000F);
    @(posedge ref_clk);
    #1 check(irq === 1'b0, "irq clear");
  endtask : run
  initial begin
    ref_clk = 1'b0;
    srst = 1'b1;
    {reg_wr, reg_rd, pp} = 3'h0;
    {reg_addr, reg_wdata} = 32'h0000_0000;
    {n_errors, num_checks, cyc, n_st} = 128'h0;
    {l_dcw, l_miw} = 9'h000;
    v = 16'($urandom(32'h0A6CFFB3));
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    rd(16'h0017, v);
    check(v === 16'h0000, "cfg reset");
    rd(16'h0030, v);
    check(v === 16'h0000, "unmapped");
    rt = 5'($urandom_range(30, 1));
    mask_m = 4'($urandom);
    wr(16'h0019, {12'h000, mask_m});
    wr(16'h0017, {7'h00, rt, 4'h0});
    for (int i = 0; i < 2; i++) begin
      vbuf[i] = 16'($urandom);
      wr(16'h0020 + 16'(i), vbuf[i]);
    end
    for (int i = 0; i < 2; i++)
      run(cw(rt, 1, 5'h10), 1, 1, 0, vbuf[pp], 1, 3, 0, 0, 0, 1);
    mask_m = 4'hF;
    wr(16'h0019, 16'h000F);
    v = 16'($urandom);
    wr(16'h0022, v);
    wr(16'h0017, {7'h00, rt, 4'h8});
    run(cw(rt, 1, 5'h10), 1, 1, 0, v, 1, 3, 0, 0, 0, 1);
    dw = 16'($urandom);
    run(cw(rt, 1, 5'h11), 1, 1, 1, dw, 0, 2, 0, 0, 0, 1);
    rd(16'h0022, v);
    check(v === dw, "descriptor store");
    wr(16'h0017, {7'h00, rt, 4'h0});
    run(cw(5'h1F, 1, 5'h10), 1, 1, 0, 0, 1, 0, 3, 3, 6'h02, 7);
    run(cw(rt, 1, 5'h10), 0, 0, 0, 0, 1, 0, 3, 0, 0, 0);
    wr(16'h0017, {7'h00, rt, 4'h4});
    run(cw(rt, 0, 5'h10), 1, 0, 0, 0, 1, 0, 3, 0, 0, 0);
    wr(16'h0017, {7'h00, rt, 4'h0});
    for (int i = 0; i < 2; i++)
      run(cw(rt, 0, i ? 5'h11 : 5'h10), 1, 1, 0, 0, 1, 2, 0, 1, 0, 1);
    run(cw(5'h1F, 0, 5'h10), 1, 1, 0, 0, 1, 0, 1, 3, 0, 3);
    wr(16'h001A, 16'h0001);
    run(cw(rt, 0, 5'h10), 1, 1, 0, 0, 1, 2, 2, 1, 6'h06, 9);
    run(cw(5'h1F, 0, 5'h10), 1, 1, 0, 0, 1, 0, 3, 3, 6'h06, 11);
    wr(16'h001A, 16'h0000);
    dw = 16'($urandom);
    run(cw(rt, 1, 5'h10), 1, 1, 1, dw, 1, 0, 2, 1, 6'h12, 5);
    run(cw(5'h1F, 1, 5'h11), 1, 1, 1, dw, 0, 0, 1, 0, 0, 1);
    // sync command whose data word never arrives
    run(cw(rt, 1, 5'h11), 1, 1, 0, 0, 1, 0, 2, 1, 6'h12, 5);
    for (int e = 0; e < 4; e++) begin
      for (int b = 0; b < 2; b++) begin
        wr(16'h0017, {7'h00, rt, 2'h0, 2'(e)});
        dw = {15'($urandom), 1'(b)};
        run(cw(rt, 1, 5'h11), 1, 1, 1, dw, 0, 2, 0, 0, 0, 1);
        check((st_tt === dw + 16'h0001) === loads(2'(e), 1'(b)), "load");
        rd(16'h0020 + 16'(pp_b), v);
        check(v === dw, "buffer store");
      end
    end
    summarize();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("MISMATCH %0t timeout", $time);
    summarize();
  end
endmodule : tb_rt_vector_sync
bind rt_vector_sync rt_vector_sync_properties #(.DW(DW)) u_chk (
  .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .cmd_strobe(cmd_strobe),
  .cmd_word(cmd_word), .cmd_ok(cmd_ok), .data_strobe(data_strobe),
  .data_word(data_word), .data_ok(data_ok), .msg_end(msg_end),
  .status_tx(status_tx), .status_word(status_word),
  .vector_tx(vector_tx), .time_tag(time_tag));
`default_nettype wire
